// file: core/acrd_readout.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module acrd_readout
  import acrd_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // Live samples from the converter
  input  wire acrd_pkg::acrd_sample_t live_sample_i,
  input  wire logic signed [acrd_pkg::QUEUE_W-1:0] queue_sample_i,
  input  wire logic                 queue_valid_i,
  // Register port
  input  wire acrd_pkg::acrd_req_t  req_i,
  output logic [7:0]                rdata_o,
  // Queue pop on output byte read
  output logic                      queue_pop_o,
  output logic                      queue_pack_8_o
);
  import acrd_pkg::*;

  // ============================================================
  // Packing helpers
  // Full scale is not handled here: scale only weights d0, the
  // bit positions are the same for every range.
  function automatic logic [15:0] pack_axis(
    input logic signed [AXIS_W-1:0] v);
    pack_axis = {v, 3'b000};
  endfunction

  function automatic logic [15:0] pack_queue(
    input logic signed [QUEUE_W-1:0] v, input acrd_pack_t m);
    logic [15:0] r;
    r = 16'h0000;
    if (m == ACRD_PACK_8) begin
      r = {v[QUEUE_W-1], v[6:0], 8'h00};
    end else begin
      r = {v[QUEUE_W-1], v[9:0], 5'b00000};
    end
    pack_queue = r;
  endfunction

  function automatic logic is_high_addr(input logic [ADDR_W-1:0] a);
    is_high_addr = (a == ADDR_X_HIGH) || (a == ADDR_Y_HIGH) ||
                   (a == ADDR_Z_HIGH);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = is_high_addr(a) || (a == ADDR_X_LOW) ||
                (a == ADDR_Y_LOW) || (a == ADDR_Z_LOW) ||
                (a == ADDR_QUEUE_OUT) || (a == ADDR_PACK_CTRL);
  endfunction

  // ============================================================
  // Capture registers
  logic [15:0] x_cap;
  logic [15:0] y_cap;
  logic [15:0] z_cap;
  logic [15:0] q_cap;
  acrd_pack_t  pack_mode;
  logic        high_rd;

  assign high_rd = req_i.rd && is_high_addr(req_i.addr);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      x_cap <= {RESET_BYTE, RESET_BYTE};
      y_cap <= {RESET_BYTE, RESET_BYTE};
      z_cap <= {RESET_BYTE, RESET_BYTE};
    end else if (high_rd) begin
      x_cap <= pack_axis(live_sample_i.x);
      y_cap <= pack_axis(live_sample_i.y);
      z_cap <= pack_axis(live_sample_i.z);
    end
  end

  // Snapshot is taken at the strobe, so the high byte answered
  // in the next cycle must come from the live value directly.
  logic [7:0]  high_now;
  logic [15:0] x_word;
  logic [15:0] y_word;
  logic [15:0] z_word;
  assign x_word = pack_axis(live_sample_i.x);
  assign y_word = pack_axis(live_sample_i.y);
  assign z_word = pack_axis(live_sample_i.z);
  always_comb begin
    high_now = UNMAPPED_BYTE;
    case (req_i.addr)
      ADDR_X_HIGH: high_now = x_word[15:8];
      ADDR_Y_HIGH: high_now = y_word[15:8];
      ADDR_Z_HIGH: high_now = z_word[15:8];
      default:     high_now = UNMAPPED_BYTE;
    endcase
  end

  // ============================================================
  // Queue output byte, high half of the packed sample
  logic q_rd;
  assign q_rd = req_i.rd && (req_i.addr == ADDR_QUEUE_OUT);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q_cap <= {RESET_BYTE, RESET_BYTE};
    end else if (q_rd && queue_valid_i) begin
      q_cap <= pack_queue(queue_sample_i, pack_mode);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pack_mode <= ACRD_PACK_11;
    end else if (req_i.wr && req_i.addr == ADDR_PACK_CTRL) begin
      pack_mode <= acrd_pack_t'(req_i.wdata[0]);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      queue_pop_o    <= 1'b0;
      queue_pack_8_o <= 1'b0;
    end else begin
      queue_pop_o    <= q_rd && queue_valid_i;
      queue_pack_8_o <= (pack_mode == ACRD_PACK_8);
    end
  end

  // ============================================================
  // Read data, valid the cycle after the strobe only
  logic [15:0] q_now;
  assign q_now = queue_valid_i ? pack_queue(queue_sample_i, pack_mode)
                               : q_cap;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RESET_BYTE;
    end else if (req_i.rd) begin
      case (req_i.addr)
        ADDR_X_LOW:     rdata_o <= x_cap[7:0];
        ADDR_Y_LOW:     rdata_o <= y_cap[7:0];
        ADDR_Z_LOW:     rdata_o <= z_cap[7:0];
        ADDR_X_HIGH,
        ADDR_Y_HIGH,
        ADDR_Z_HIGH:    rdata_o <= high_now;
        ADDR_QUEUE_OUT: rdata_o <= q_now[15:8];
        ADDR_PACK_CTRL: rdata_o <= {7'h00, pack_mode};
        default:        rdata_o <= UNMAPPED_BYTE;
      endcase
    end else begin
      rdata_o <= RESET_BYTE;
    end
  end

  // ============================================================
  // Checks
  snapshot_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_HIGH ##1
    req_i.rd && req_i.addr == ADDR_X_LOW
    |=> rdata_o == {$past(live_sample_i.x[4:0], 2), 3'b000})
    else $error("low byte not from snapshot");
  hold_capture_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !high_rd |=> $stable(x_cap) && $stable(y_cap) && $stable(z_cap))
    else $error("capture changed without high read");
  low_unused_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(req_i.rd) && $past(req_i.addr) == ADDR_Y_LOW
    |-> rdata_o[2:0] == 3'b000)
    else $error("low unused bits set");
  sign_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Z_HIGH
    |=> rdata_o[SIGN_POS] == $past(live_sample_i.z[AXIS_W-1]))
    else $error("sign bit wrong");
  zero_value_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_HIGH && live_sample_i.x == '0
    |=> rdata_o == 8'h00)
    else $error("zero sample not zero");
  queue_pack8_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pack_mode == ACRD_PACK_8 && queue_valid_i |-> q_now[7:0] == 8'h00)
    else $error("8-bit low bits used");
  queue_pack11_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pack_mode == ACRD_PACK_11 && queue_valid_i |-> q_now[4:0] == 5'b00000)
    else $error("11-bit low bits used");
  idle_rdata_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !req_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside answer");
  weight_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    high_rd |=> x_cap[3] == $past(live_sample_i.x[0]))
    else $error("d0 misplaced");

  // ============================================================
  // Axis high bytes and snapshot contents
  x_high_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_HIGH
    |=> rdata_o == $past(live_sample_i.x[12:5]))
    else $error("x high byte wrong");
  y_high_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Y_HIGH
    |=> rdata_o == $past(live_sample_i.y[12:5]))
    else $error("y high byte wrong");
  z_high_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Z_HIGH
    |=> rdata_o == $past(live_sample_i.z[12:5]))
    else $error("z high byte wrong");
  x_sign_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_HIGH
    |=> rdata_o[SIGN_POS] == $past(live_sample_i.x[AXIS_W-1]))
    else $error("x sign bit wrong");
  y_sign_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Y_HIGH
    |=> rdata_o[SIGN_POS] == $past(live_sample_i.y[AXIS_W-1]))
    else $error("y sign bit wrong");
  x_capture_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    high_rd
    |=> x_cap == {$past(live_sample_i.x), 3'b000})
    else $error("x snapshot wrong");
  y_capture_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    high_rd
    |=> y_cap == {$past(live_sample_i.y), 3'b000})
    else $error("y snapshot wrong");
  z_capture_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    high_rd
    |=> z_cap == {$past(live_sample_i.z), 3'b000})
    else $error("z snapshot wrong");

  // ============================================================
  // Axis low bytes, zero high bytes and d0 positions
  x_low_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_LOW
    |=> rdata_o == $past(x_cap[7:0]))
    else $error("x low byte not held");
  y_low_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Y_LOW
    |=> rdata_o == $past(y_cap[7:0]))
    else $error("y low byte not held");
  z_low_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Z_LOW
    |=> rdata_o == $past(z_cap[7:0]))
    else $error("z low byte not held");
  x_low_unused_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_X_LOW
    |=> rdata_o[2:0] == 3'b000)
    else $error("x low unused bits set");
  z_low_unused_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Z_LOW
    |=> rdata_o[2:0] == 3'b000)
    else $error("z low unused bits set");
  y_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Y_HIGH && live_sample_i.y == '0
    |=> rdata_o == 8'h00)
    else $error("y zero sample not zero");
  z_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_Z_HIGH && live_sample_i.z == '0
    |=> rdata_o == 8'h00)
    else $error("z zero sample not zero");
  y_weight_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    high_rd
    |=> y_cap[3] == $past(live_sample_i.y[0]))
    else $error("y d0 misplaced");
  z_weight_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    high_rd
    |=> z_cap[3] == $past(live_sample_i.z[0]))
    else $error("z d0 misplaced");

  // ============================================================
  // Queue output byte
  queue_8_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && queue_valid_i && pack_mode == ACRD_PACK_8
    |=> rdata_o == {$past(queue_sample_i[12]), $past(queue_sample_i[6:0])})
    else $error("8-bit queue byte wrong");
  queue_11_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && queue_valid_i && pack_mode == ACRD_PACK_11
    |=> rdata_o == {$past(queue_sample_i[12]), $past(queue_sample_i[9:3])})
    else $error("11-bit queue byte wrong");
  queue_sign_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && queue_valid_i
    |=> rdata_o[SIGN_POS] == $past(queue_sample_i[QUEUE_W-1]))
    else $error("queue sign bit wrong");
  queue_held_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && !queue_valid_i
    |=> rdata_o == $past(q_cap[15:8]))
    else $error("empty queue read wrong");
  queue_pop_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && queue_valid_i
    |=> queue_pop_o)
    else $error("queue pop missing");
  queue_nopop_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(q_rd && queue_valid_i)
    |=> !queue_pop_o)
    else $error("queue pop without read");
  queue_cap_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(q_rd && queue_valid_i)
    |=> $stable(q_cap))
    else $error("queue capture changed");
  queue_capture_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    q_rd && queue_valid_i
    |=> q_cap == $past(pack_queue(queue_sample_i, pack_mode)))
    else $error("queue capture wrong");

  // ============================================================
  // Address map and packing control
  unmapped_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && !is_mapped(req_i.addr)
    |=> rdata_o == UNMAPPED_BYTE)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ADDR_PACK_CTRL
    |=> rdata_o == {7'h00, $past(pack_mode)})
    else $error("packing control read wrong");
  mode_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(req_i.wr && req_i.addr == ADDR_PACK_CTRL)
    |=> $stable(pack_mode))
    else $error("packing mode changed");
  mode_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    1'b1
    |=> queue_pack_8_o == ($past(pack_mode) == ACRD_PACK_8))
    else $error("packing flag wrong");

endmodule
`default_nettype wire

// file: core/acrd_pkg.sv
`default_nettype none
package acrd_pkg;

  // Register map, byte-wide registers at their printed offsets
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  ADDR_X_LOW      = 6'h04;
  localparam logic [5:0]  ADDR_X_HIGH     = 6'h05;
  localparam logic [5:0]  ADDR_Y_LOW      = 6'h06;
  localparam logic [5:0]  ADDR_Y_HIGH     = 6'h07;
  localparam logic [5:0]  ADDR_Z_LOW      = 6'h08;
  localparam logic [5:0]  ADDR_Z_HIGH     = 6'h09;
  localparam logic [5:0]  ADDR_QUEUE_OUT  = 6'h0F;
  localparam logic [5:0]  ADDR_PACK_CTRL  = 6'h10;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [7:0]  UNMAPPED_BYTE   = 8'h00;

  // Sample widths: 12 data bits plus sign for axes
  localparam int          AXIS_W          = 13;
  localparam int          QUEUE_W         = 13;
  localparam int          SIGN_POS        = 7;

  // Queue packing modes
  typedef enum logic {
    ACRD_PACK_11 = 1'b0,
    ACRD_PACK_8  = 1'b1
  } acrd_pack_t;

  // One captured sample of three axes
  typedef struct packed {
    logic signed [AXIS_W-1:0] x;
    logic signed [AXIS_W-1:0] y;
    logic signed [AXIS_W-1:0] z;
  } acrd_sample_t;

  // Host register access request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } acrd_req_t;

endpackage
`default_nettype wire

// file: verif/acrd_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Host model
module acrd_host
  import acrd_pkg::*;
(
  // Clock
  input  wire logic            clk_i,
  // Register port
  output var acrd_pkg::acrd_req_t req_o,
  input  wire logic [7:0]      rdata_i
);
  initial req_o = '0;
  // Idle edge after a write keeps strobes apart
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    @(posedge clk_i);
  endtask
  // Outside the reset checks, callers read a high byte before any low byte
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(posedge clk_i);
    d = rdata_i;
  endtask
  // Two reads with no gap, each answer taken a cycle after its strobe
  task automatic rd_pair(input logic [5:0] a1, a2,
                         output logic [7:0] d1, d2);
    req_o <= '{addr: a1, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o <= '{addr: a2, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    d1 = rdata_i;
    req_o <= '{addr: ~a2, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(posedge clk_i);
    d2 = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acrd_pkg::*;
  logic                      clk_sys_i, rst_i, queue_valid_i, pop, pack_8;
  acrd_sample_t              live;
  logic signed [QUEUE_W-1:0] qs;
  acrd_req_t                 req;
  logic [7:0]                rdata, d, d2;
  int                        n_errors = 0;
  int                        samples_checked = 0;
  logic [5:0] addrs [7] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0F};
  logic [12:0] q_tab [4] = '{13'h0000, 13'h1FFF, 13'h0FFF, 13'h1000};
  logic [7:0]  q_exp [4] = '{8'h00, 8'hFF, 8'h7F, 8'h80};
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  acrd_readout dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .live_sample_i(live), .queue_sample_i(qs), .queue_valid_i(queue_valid_i),
    .req_i(req), .rdata_o(rdata), .queue_pop_o(pop), .queue_pack_8_o(pack_8));
  acrd_host host (.clk_i(clk_sys_i), .req_o(req), .rdata_i(rdata));
  // ====================
  // Checks
  function automatic logic [7:0] hi(input logic [12:0] v);
    return v[12:5];
  endfunction
  function automatic logic [7:0] lo(input logic [12:0] v);
    return {v[4:0], 3'b000};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, logic [7:0] e);
    host.rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded well above the fewer than a hundred cycles needed
  initial begin
    #25000;
    n_errors++;
    final_report;
  end
  initial begin
    rst_i = 1'b1;
    queue_valid_i = 1'b0;
    live = '0;
    qs = '0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    foreach (addrs[i]) rdc("reset", addrs[i], 8'h00);
    live <= '{x: 13'h0ABC, y: 13'h1234, z: 13'h0F0F};
    rdc("x high", ADDR_X_HIGH, hi(13'h0ABC));
    live <= '{x: 13'h1555, y: 13'h0AAA, z: 13'h1001};
    rdc("x low", ADDR_X_LOW, lo(13'h0ABC));
    rdc("y low", ADDR_Y_LOW, lo(13'h1234));
    rdc("z low", ADDR_Z_LOW, lo(13'h0F0F));
    rdc("z high", ADDR_Z_HIGH, hi(13'h1001));
    rdc("x low new", ADDR_X_LOW, lo(13'h1555));
    host.wr(ADDR_X_LOW, 8'h5A);
    rdc("ro low", ADDR_X_LOW, lo(13'h1555));
    rdc("unmapped", 6'h0A, UNMAPPED_BYTE);
    live <= '{x: 13'h0123, y: 13'h0456, z: 13'h1789};
    host.rd_pair(ADDR_X_HIGH, ADDR_X_LOW, d, d2);
    chk("pair high", d, hi(13'h0123));
    chk("pair low", d2, lo(13'h0123));
    queue_valid_i <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      host.wr(ADDR_PACK_CTRL, 8'(m));
      @(posedge clk_sys_i);
      chk("pack mode", {7'h00, pack_8}, 8'(m));
      qs <= 13'h0078;
      rdc("queue mode", ADDR_QUEUE_OUT, m ? 8'h78 : 8'h0F);
      foreach (q_tab[i]) begin
        qs <= q_tab[i];
        rdc("queue byte", ADDR_QUEUE_OUT, q_exp[i]);
        chk("queue pop", {7'h00, pop}, 8'h01);
      end
    end
    queue_valid_i <= 1'b0;
    host.rd(ADDR_QUEUE_OUT, d);
    chk("idle pop", {7'h00, pop}, 8'h00);
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rdc("low after reset", ADDR_X_LOW, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
